/* hdl/btp_pc_unit.sv */
// program counter update and branch target generation
`timescale 1ns/1ps
module btp_pc_unit (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic exec_in,
  input wire btp_pkg::btp_op_t op_in,
  input wire logic [btp_pkg::LEN_W-1:0] length_in,
  input wire logic [7:0] opcode_in,
  input wire logic [7:0] relative_displacement_in,
  input wire logic [15:0] absolute_target_field_in,
  input wire logic [15:0] accumulator_register_pair_in,
  input wire logic [7:0] mem_data_in,
  input wire logic mem_valid_in,
  output logic [15:0] pc_out,
  output logic busy_out,
  output logic mem_req_out,
  output logic [15:0] mem_addr_out
);
  import btp_pkg::*;

  typedef struct packed {
    logic [15:0] pc;
    btp_state_t st;
    logic [7:0] lo;
    logic req;
    logic [15:0] addr;
  } btp_regs_t;

  btp_regs_t r;
  btp_regs_t next_r;
  logic [15:0] seq_pc;
  logic [15:0] rel_pc;
  logic [15:0] vec_addr;

  //////////////////////////////////////////////////////////////////////////////
  // sequential address and relative target
  always_comb begin
    seq_pc = r.pc + {13'h0000, length_in};
  end

  btp_rel_adder u_add (
    .base_in(seq_pc),
    .disp_in(relative_displacement_in),
    .sum_out(rel_pc)
  );

  always_comb begin
    vec_addr = TABLE_BASE | {10'h000, opcode_in[INDEX_HI:INDEX_LO], 1'b0};
  end

  //////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    next_r = r;
    case (r.st)
      BTP_ST_IDLE: begin
        if (exec_in) begin
          case (op_in)
            BTP_OP_SEQ: next_r.pc = seq_pc;
            BTP_OP_REL: next_r.pc = rel_pc;
            BTP_OP_ABS: next_r.pc = absolute_target_field_in;
            BTP_OP_REG: next_r.pc = accumulator_register_pair_in;
            BTP_OP_TBL: begin
              next_r.st = BTP_ST_RD_LO;
              next_r.req = 1'b1;
              next_r.addr = vec_addr;
            end
            default: next_r.pc = seq_pc;
          endcase
        end
      end
      BTP_ST_RD_LO: begin
        if (mem_valid_in) begin
          next_r.lo = mem_data_in;
          next_r.addr = r.addr + 16'h0001;
          next_r.st = BTP_ST_RD_HI;
        end
      end
      BTP_ST_RD_HI: begin
        if (mem_valid_in) begin
          next_r.pc = {mem_data_in, r.lo};
          next_r.req = 1'b0;
          next_r.st = BTP_ST_IDLE;
        end
      end
      default: begin
        next_r.st = BTP_ST_IDLE;
        next_r.req = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      r <= '{pc: RESET_PC, st: BTP_ST_IDLE, lo: 8'h00, req: 1'b0, addr: 16'h0000};
    end else begin
      r <= next_r;
    end
  end

  always_comb begin
    pc_out = r.pc;
    mem_req_out = r.req;
    mem_addr_out = r.addr;
    busy_out = r.req;
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_tbl_start;
    exec_in && !busy_out && op_in == BTP_OP_TBL;
  endsequence

  a_seq_advance: assert property (@(posedge clk_in) disable iff (srst_in)
    exec_in && !busy_out && op_in == BTP_OP_SEQ |=> pc_out == $past(pc_out) + {13'h0000, $past(length_in)})
    else $error("sequential pc step wrong");
  a_rel_target: assert property (@(posedge clk_in) disable iff (srst_in)
    exec_in && !busy_out && op_in == BTP_OP_REL |=> pc_out == 16'($past(pc_out) + $past(length_in)
      + {{8{$past(relative_displacement_in[7])}}, $past(relative_displacement_in)}))
    else $error("relative target wrong");
  a_rel_back: assert property (@(posedge clk_in) disable iff (srst_in)
    exec_in && !busy_out && op_in == BTP_OP_REL && relative_displacement_in == 8'h80 && length_in == 3'h2
    |=> pc_out == 16'($past(pc_out) - 16'h007E))
    else $error("negative displacement wrong");
  a_rel_ext: assert property (@(posedge clk_in) disable iff (srst_in)
    exec_in && !busy_out && op_in == BTP_OP_REL && !relative_displacement_in[7]
    |=> pc_out - $past(seq_pc) == {8'h00, $past(relative_displacement_in)})
    else $error("displacement extension wrong");
  a_abs_load: assert property (@(posedge clk_in) disable iff (srst_in)
    exec_in && !busy_out && op_in == BTP_OP_ABS |=> pc_out == $past(absolute_target_field_in))
    else $error("absolute target wrong");
  a_reg_load: assert property (@(posedge clk_in) disable iff (srst_in)
    exec_in && !busy_out && op_in == BTP_OP_REG |=> pc_out == $past(accumulator_register_pair_in))
    else $error("register target wrong");
  a_tbl_addr: assert property (@(posedge clk_in) disable iff (srst_in)
    s_tbl_start |=> mem_req_out && mem_addr_out == 16'h0040 + {10'h000, $past(opcode_in[5:1]), 1'b0})
    else $error("vector address wrong");
  a_tbl_range: assert property (@(posedge clk_in) disable iff (srst_in)
    mem_req_out |-> mem_addr_out >= TABLE_BASE && mem_addr_out <= TABLE_LAST)
    else $error("vector read outside table");
  a_tbl_load: assert property (@(posedge clk_in) disable iff (srst_in)
    r.st == BTP_ST_RD_HI && mem_valid_in |=> pc_out == {$past(mem_data_in), $past(r.lo)} && !mem_req_out)
    else $error("vector load wrong");
  a_hold_busy: assert property (@(posedge clk_in) disable iff (srst_in)
    busy_out && !(r.st == BTP_ST_RD_HI && mem_valid_in) |=> pc_out == $past(pc_out))
    else $error("pc moved during vector fetch");

  //////////////////////////////////////////////////////////////////////////////
  // vector fetch steps, negative displacement extension, reset state and idle behaviour
  sequence s_vec_lo;
    r.st == BTP_ST_RD_LO && mem_valid_in;
  endsequence

  sequence s_idle_quiet;
    !exec_in && !busy_out;
  endsequence

  a_tbl_next: assert property (@(posedge clk_in) disable iff (srst_in)
    s_vec_lo |=> mem_req_out && mem_addr_out == 16'($past(mem_addr_out) + 16'h0001) && r.lo == $past(mem_data_in))
    else $error("vector high byte fetch wrong");
  a_tbl_pc_hold: assert property (@(posedge clk_in) disable iff (srst_in)
    s_tbl_start |=> pc_out == $past(pc_out) && busy_out)
    else $error("pc moved at vector fetch start");
  a_rel_sign: assert property (@(posedge clk_in) disable iff (srst_in)
    exec_in && !busy_out && op_in == BTP_OP_REL && relative_displacement_in[7]
    |=> 16'(pc_out - $past(seq_pc)) == {8'hFF, $past(relative_displacement_in)})
    else $error("negative displacement extension wrong");
  a_idle_hold: assert property (@(posedge clk_in) disable iff (srst_in)
    s_idle_quiet |=> pc_out == $past(pc_out) && !mem_req_out)
    else $error("pc moved without an instruction");
  a_reset_state: assert property (@(posedge clk_in)
    srst_in |=> pc_out == RESET_PC && !busy_out && !mem_req_out && mem_addr_out == 16'h0000)
    else $error("reset state wrong");
endmodule

/* shared/btp_pkg.sv */
// constants and types for the branch target and program counter logic
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
package btp_pkg;
  localparam int ADDR_W = 16;
  localparam int LEN_W = 3;
  localparam logic [15:0] RESET_PC = 16'h0000;
  localparam logic [15:0] TABLE_BASE = 16'h0040;
  localparam logic [15:0] TABLE_LAST = 16'h007F;
  localparam int INDEX_LO = 1;
  localparam int INDEX_HI = 5;
  localparam int SIGN_BIT = 7;

  // branch operation requested by the decoder
  typedef enum logic [2:0] {
    BTP_OP_SEQ = 3'b000,
    BTP_OP_REL = 3'b001,
    BTP_OP_ABS = 3'b010,
    BTP_OP_TBL = 3'b011,
    BTP_OP_REG = 3'b100
  } btp_op_t;

  typedef enum logic [1:0] {
    BTP_ST_IDLE = 2'b00,
    BTP_ST_RD_LO = 2'b01,
    BTP_ST_RD_HI = 2'b10
  } btp_state_t;
endpackage

/* hdl/btp_rel_adder.sv */
// signed displacement adder for relative branch targets
`timescale 1ns/1ps
module btp_rel_adder (
  input wire logic [15:0] base_in,
  input wire logic [7:0] disp_in,
  output logic [15:0] sum_out
);
  import btp_pkg::*;
  logic [15:0] disp_ext;
  always_comb begin
    disp_ext = {{8{disp_in[SIGN_BIT]}}, disp_in};
    sum_out = base_in + disp_ext;
  end
endmodule

/* verification/btp_mem_model.sv */
// program memory model answering vector table reads
`timescale 1ns/1ps
module btp_mem_model (
  input wire logic clk_in,
  input wire logic slow_in,
  input wire logic mem_req_in,
  input wire logic [15:0] mem_addr_in,
  output logic [7:0] mem_data_out,
  output logic mem_valid_out
);
  initial begin
    mem_data_out = 8'h00;
    mem_valid_out = 1'b0;
  end
  // idle data toggles so a stale byte is never mistaken for a fresh one
  always @(posedge clk_in) begin
    if (mem_req_in && !mem_valid_out && (!slow_in || ($urandom % 3 == 0))) begin
      mem_valid_out <= 1'b1;
      mem_data_out <= mem_addr_in[7:0] * 8'h3B ^ 8'h5C;
    end else begin
      mem_valid_out <= 1'b0;
      mem_data_out <= ~mem_data_out;
    end
  end
endmodule

/* verification/branch_target_pc_logic_tb.sv */
// self-checking bench for the program counter unit
`timescale 1ns/1ps
module branch_target_pc_logic_tb;
  import btp_pkg::*;
  logic clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic exec = 1'b0, slow = 1'b0, busy, req, vld;
  btp_op_t op_r = BTP_OP_SEQ;
  logic [2:0] len_r = 3'h0;
  logic [7:0] opc_r = 8'h00, disp_r = 8'h00, mdata;
  logic [15:0] abs_r = 16'h0000, acc_r = 16'h0000, pc, maddr, exp_pc = 16'h0000;
  int mismatches = 0, check_count = 0, cycles = 0;
  initial forever #5 clk_in = ~clk_in;
  btp_pc_unit u_dut (.clk_in(clk_in), .srst_in(srst_in), .exec_in(exec), .op_in(op_r), .length_in(len_r),
    .opcode_in(opc_r), .relative_displacement_in(disp_r), .absolute_target_field_in(abs_r),
    .accumulator_register_pair_in(acc_r), .mem_data_in(mdata), .mem_valid_in(vld), .pc_out(pc),
    .busy_out(busy), .mem_req_out(req), .mem_addr_out(maddr));
  btp_mem_model u_mem (.clk_in(clk_in), .slow_in(slow), .mem_req_in(req), .mem_addr_in(maddr),
    .mem_data_out(mdata), .mem_valid_out(vld));
  task automatic wrap_up();
    if (mismatches == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    check_count++;
    if (seen !== want) begin
      mismatches++;
      $display("ERROR %0t value %h expected %h", $time, seen, want);
    end
  endtask
  function automatic logic [7:0] vb(input logic [15:0] a);
    return a[7:0] * 8'h3B ^ 8'h5C;
  endfunction
  //////////////////////////////////////////////////////////////////////////////
  task automatic run(input logic [2:0] op, input logic [2:0] len, input logic [7:0] opc, input logic [7:0] d,
    input logic [15:0] t);
    logic [15:0] e, v;
    int n;
    v = 16'h0040 + {10'h000, opc[5:1], 1'b0};
    case (op)
      3'd1: e = exp_pc + len + {{8{d[7]}}, d};
      3'd2, 3'd4: e = t;
      3'd3: e = {vb(v + 16'h0001), vb(v)};
      default: e = exp_pc + len;
    endcase
    @(posedge clk_in);
    exec <= 1'b1;
    slow <= 1'($urandom % 2);
    op_r <= btp_op_t'(op);
    len_r <= len;
    opc_r <= opc;
    disp_r <= d;
    abs_r <= (op == 3'd4) ? ~t : t;
    acc_r <= (op == 3'd2) ? ~t : t;
    @(posedge clk_in);
    exec <= 1'b0;
    #1;
    n = 0;
    while (busy === 1'b1 && n < 50) begin
      check({15'h0000, maddr[15:6] === 10'h001}, 16'h0001);
      check({15'h0000, req}, 16'h0001);
      @(posedge clk_in);
      #1;
      n++;
    end
    check(pc, e);
    exp_pc = e;
  endtask
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      wrap_up();
    end
  end
  initial begin
    void'($urandom(99652));
    repeat (3) @(posedge clk_in);
    srst_in <= 1'b0;
    @(posedge clk_in);
    #1;
    check(pc, RESET_PC);
    check({14'h0000, busy, req}, 16'h0000);
    run(3'd4, 3'd1, 8'h00, 8'h00, 16'hFFFE);
    run(3'd1, 3'd2, 8'h00, 8'h7F, 16'h0000);
    run(3'd1, 3'd1, 8'h00, 8'h80, 16'h0000);
    run(3'd3, 3'd1, 8'h00, 8'h00, 16'h0000);
    run(3'd3, 3'd1, 8'hFF, 8'h00, 16'h0000);
    repeat (150) run(3'($urandom % 8), 3'($urandom % 4 + 1), 8'($urandom), 8'($urandom), 16'($urandom));
    @(posedge clk_in);
    srst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    srst_in <= 1'b0;
    #1;
    check(pc, RESET_PC);
    check({14'h0000, busy, req}, 16'h0000);
    exp_pc = RESET_PC;
    run(3'd1, 3'd2, 8'h00, 8'h80, 16'h0000);
    repeat (150) run(3'($urandom % 8), 3'($urandom % 4 + 1), 8'($urandom), 8'($urandom), 16'($urandom));
    wrap_up();
  end
endmodule
